// ===== verilog/rsf_pkg.sv
// rsf_pkg: register map, field layout and reset values of the ramp/fault bank
package rsf_pkg;

  // register offsets on the control port
  localparam logic [7:0] OFF_SPREAD_MAIN   = 8'h6b;
  localparam logic [7:0] OFF_SPREAD_RANGE  = 8'h6c;
  localparam logic [7:0] OFF_RAMP_DIVISOR  = 8'h6d;
  localparam logic [7:0] OFF_STEP_SIZES    = 8'h6e;
  localparam logic [7:0] OFF_AMP_BOUNDARY  = 8'h6f;
  localparam logic [7:0] OFF_CHANNEL_FAULT_FLAGS    = 8'h70;
  localparam logic [7:0] OFF_GLOBAL_FAULT  = 8'h71;
  localparam logic [7:0] OFF_FAULT_CLEAR   = 8'h78;

  // reset values
  localparam logic [7:0] RST_SPREAD_MAIN   = 8'h00;
  localparam logic [7:0] RST_SPREAD_RANGE  = 8'h00;
  localparam logic [7:0] RST_RAMP_DIVISOR  = 8'h50;
  localparam logic [7:0] RST_STEP_SIZES    = 8'h11;
  localparam logic [7:0] RST_AMP_BOUNDARY  = 8'h24;
  localparam logic [7:0] READ_ZERO         = 8'h00;

  // spread_control_main fields
  localparam int BIT_PRE_DIV       = 5;
  localparam int BIT_MANUAL        = 4;
  localparam int BIT_RANDOM_ON     = 1;
  localparam int BIT_TRIANGLE_ON   = 0;

  // spread_range_select fields
  localparam int RANDOM_RANGE_HI   = 6;
  localparam int RANDOM_RANGE_LO   = 4;
  localparam int TRI_SEL_HI        = 3;
  localparam int TRI_SEL_LO        = 0;

  // triangle_step_sizes fields
  localparam int FALL_STEP_HI      = 7;
  localparam int FALL_STEP_LO      = 4;
  localparam int RISE_STEP_HI      = 3;
  localparam int RISE_STEP_LO      = 0;

  // ramp_amplitude_boundary fields
  localparam int AMP_HI            = 6;
  localparam int AMP_LO            = 5;
  localparam int BOUND_HI          = 4;
  localparam int BOUND_LO          = 0;

  // fault-clear trigger bit
  localparam int BIT_FAULT_CLEAR   = 7;

  // global_fault_flags_a bit positions
  localparam int BIT_OTP_CRC       = 7;
  localparam int BIT_BIQUAD        = 6;
  localparam int BIT_CLOCK_FAULT   = 2;

  // index of each flag inside the sticky flag bank
  localparam int FLAG_RIGHT_OC     = 0;
  localparam int FLAG_LEFT_OC      = 1;
  localparam int FLAG_RIGHT_DC     = 2;
  localparam int FLAG_LEFT_DC      = 3;
  localparam int FLAG_CLOCK        = 4;
  localparam int FLAG_BIQUAD       = 5;
  localparam int FLAG_OTP_CRC      = 6;
  localparam int NUM_FLAGS         = 7;
  localparam int NUM_CHAN_FLAGS    = 4;

  // manual ramp frequency is this reference divided by the divisor
  localparam int unsigned RAMP_REF_HZ = 61440000;

endpackage : rsf_pkg

// ===== verilog/rsf_sticky_flags.sv
// rsf_sticky_flags: bank of sticky flags where a set beats a same-cycle clear
`timescale 1ns/100ps
module rsf_sticky_flags
#(
  parameter int W = 7
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // per-flag set and clear strobes
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flag state
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_flag
      // set wins so an event in the clearing cycle is never lost
      assign flags_next[g] = set[g] | (flags_reg[g] & ~clr[g]);
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  assign flags = flags_reg;

endmodule // rsf_sticky_flags

// ===== verilog/rsf_regs.sv
// rsf_regs: ramp spread-spectrum control registers and sticky fault flags
//
// What this block does
// - manual bit selects manual ramp settings
// - manual pre-divide bit halves ramp source clock
// - random spread enable and 3-bit range
// - triangle spread enable and 4-bit select
// - manual ramp frequency from 8-bit divisor
// - manual triangle fall step, four bits
// - manual triangle rise step, four bits
// - manual ramp amplitude, two bits
// - manual triangle sweep boundary, five bits
// - left DC fault sets channel bit 3
// - right DC fault sets channel bit 2
// - left over-current sets channel bit 1
// - right over-current sets channel bit 0
// - channel fault forces power outputs high-impedance
// - channel fault drives the fault pin
// - channel flags held until clear bit written
// - OTP CRC error sets global bit 7
// - failed biquad write sets global bit 6
// - fault-clear register sits at 0x78
// - clock error sets bit 2, Hi-Z until gone
`timescale 1ns/100ps
module rsf_regs
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  // register port from the control bus decoder
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  // fault detector events
  input  wire logic       LEFT_DC_EVT,
  input  wire logic       RIGHT_DC_EVT,
  input  wire logic       LEFT_OC_EVT,
  input  wire logic       RIGHT_OC_EVT,
  input  wire logic       OTP_CRC_EVT,
  input  wire logic       BIQUAD_WR_FAIL,
  input  wire logic       BIQUAD_WR_OK,
  input  wire logic       CLOCK_ERROR,
  // ramp spread-spectrum controller settings
  output logic            MANUAL_MODE,
  output logic            SRC_DIV2,
  output logic            RANDOM_SPREAD_ON,
  output logic            TRIANGLE_SPREAD_ON,
  output logic      [2:0] RANDOM_SPREAD_RANGE,
  output logic      [3:0] TRIANGLE_SELECT,
  output logic      [7:0] MANUAL_RAMP_DIVISOR_N,
  output logic      [3:0] TRIANGLE_FALL_STEP,
  output logic      [3:0] TRIANGLE_RISE_STEP,
  output logic      [1:0] RAMP_AMPLITUDE_SETTING,
  output logic      [4:0] TRIANGLE_SWEEP_BOUNDARY,
  // power stage and fault pin
  output logic            OUTPUT_HIZ,
  output logic            FAULT_N
);

  // address match, shared by the write and read decoders
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  // stored registers
  logic [7:0] spread_main_reg;
  logic [7:0] spread_main_next;
  logic [7:0] spread_range_reg;
  logic [7:0] spread_range_next;
  logic [7:0] ramp_divisor_reg;
  logic [7:0] ramp_divisor_next;
  logic [7:0] step_sizes_reg;
  logic [7:0] step_sizes_next;
  logic [7:0] amp_boundary_reg;
  logic [7:0] amp_boundary_next;

  // read path
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;

  // write decode
  wire        wr_spread_main;
  wire        wr_spread_range;
  wire        wr_ramp_divisor;
  wire        wr_step_sizes;
  wire        wr_amp_boundary;
  wire        wr_fault_clear;
  wire        fault_clear_pulse;

  // read decode
  wire        rd_spread_main;
  wire        rd_spread_range;
  wire        rd_ramp_divisor;
  wire        rd_step_sizes;
  wire        rd_amp_boundary;
  wire        rd_channel_fault_flags;
  wire        rd_global_fault;

  // flag bank wiring
  logic [rsf_pkg::NUM_FLAGS-1:0] flag_set;
  logic [rsf_pkg::NUM_FLAGS-1:0] flag_clr;
  logic [rsf_pkg::NUM_FLAGS-1:0] flags;

  // fault views
  wire  [7:0] channel_fault_flags_view;
  wire  [7:0] global_fault_view;
  logic [7:0] global_fault_view_c;
  wire        channel_fault_flags_any;
  wire        hiz_next;
  logic       hiz_reg;
  logic       fault_n_reg;

  // controller setting views
  wire        manual_on;
  wire        div2_next;
  wire  [2:0] random_range_field;
  wire  [3:0] tri_select_field;
  wire  [3:0] fall_step_field;
  wire  [3:0] rise_step_field;
  wire  [1:0] amp_field;
  wire  [4:0] boundary_field;
  wire  [7:0] divisor_eff;
  wire  [3:0] fall_step_eff;
  wire  [3:0] rise_step_eff;
  wire  [1:0] amp_eff;
  wire  [4:0] boundary_eff;

  // settings flops
  logic       manual_reg;
  logic       div2_reg;
  logic       random_on_reg;
  logic       tri_on_reg;
  logic [2:0] random_range_reg;
  logic [3:0] tri_select_reg;
  logic [7:0] divisor_out_reg;
  logic [3:0] fall_step_reg;
  logic [3:0] rise_step_reg;
  logic [1:0] amp_reg;
  logic [4:0] boundary_reg;

  // write decode
  assign wr_spread_main  = REG_WR &
                           addr_hit(REG_ADDR, rsf_pkg::OFF_SPREAD_MAIN);
  assign wr_spread_range = REG_WR &
                           addr_hit(REG_ADDR, rsf_pkg::OFF_SPREAD_RANGE);
  assign wr_ramp_divisor = REG_WR &
                           addr_hit(REG_ADDR, rsf_pkg::OFF_RAMP_DIVISOR);
  assign wr_step_sizes   = REG_WR &
                           addr_hit(REG_ADDR, rsf_pkg::OFF_STEP_SIZES);
  assign wr_amp_boundary = REG_WR &
                           addr_hit(REG_ADDR, rsf_pkg::OFF_AMP_BOUNDARY);
  assign wr_fault_clear  = REG_WR &
                           addr_hit(REG_ADDR, rsf_pkg::OFF_FAULT_CLEAR);
  assign fault_clear_pulse = wr_fault_clear &
                             REG_WDATA[rsf_pkg::BIT_FAULT_CLEAR];

  // reserved bits are stored and read back but steer nothing
  assign spread_main_next  = wr_spread_main  ? REG_WDATA : spread_main_reg;
  assign spread_range_next = wr_spread_range ? REG_WDATA : spread_range_reg;
  assign ramp_divisor_next = wr_ramp_divisor ? REG_WDATA : ramp_divisor_reg;
  assign step_sizes_next   = wr_step_sizes   ? REG_WDATA : step_sizes_reg;
  assign amp_boundary_next = wr_amp_boundary ? REG_WDATA : amp_boundary_reg;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      spread_main_reg  <= rsf_pkg::RST_SPREAD_MAIN;
      spread_range_reg <= rsf_pkg::RST_SPREAD_RANGE;
      ramp_divisor_reg <= rsf_pkg::RST_RAMP_DIVISOR;
      step_sizes_reg   <= rsf_pkg::RST_STEP_SIZES;
      amp_boundary_reg <= rsf_pkg::RST_AMP_BOUNDARY;
    end
    else
    begin
      spread_main_reg  <= spread_main_next;
      spread_range_reg <= spread_range_next;
      ramp_divisor_reg <= ramp_divisor_next;
      step_sizes_reg   <= step_sizes_next;
      amp_boundary_reg <= amp_boundary_next;
    end
  end

  // fault flag sources
  always_comb
  begin
    flag_set = '0;
    flag_clr = {rsf_pkg::NUM_FLAGS{fault_clear_pulse}};
    flag_set[rsf_pkg::FLAG_LEFT_DC]  = LEFT_DC_EVT;
    flag_set[rsf_pkg::FLAG_RIGHT_DC] = RIGHT_DC_EVT;
    flag_set[rsf_pkg::FLAG_LEFT_OC]  = LEFT_OC_EVT;
    flag_set[rsf_pkg::FLAG_RIGHT_OC] = RIGHT_OC_EVT;
    flag_set[rsf_pkg::FLAG_OTP_CRC]  = OTP_CRC_EVT;
    flag_set[rsf_pkg::FLAG_CLOCK]    = CLOCK_ERROR;
    flag_set[rsf_pkg::FLAG_BIQUAD]   = BIQUAD_WR_FAIL;
    // the biquad flag tracks the latest write, so a good write clears it
    flag_clr[rsf_pkg::FLAG_BIQUAD]   = fault_clear_pulse |
                                       BIQUAD_WR_OK;
  end

  rsf_sticky_flags
  #(
    .W     (rsf_pkg::NUM_FLAGS)
  )
  u_flags
  (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .set   (flag_set),
    .clr   (flag_clr),
    .flags (flags)
  );

  // register views of the flag bank
  assign channel_fault_flags_view = {
    4'h0,
    flags[rsf_pkg::FLAG_LEFT_DC],
    flags[rsf_pkg::FLAG_RIGHT_DC],
    flags[rsf_pkg::FLAG_LEFT_OC],
    flags[rsf_pkg::FLAG_RIGHT_OC]
  };

  always_comb
  begin
    // supply faults live elsewhere; their bits read as zero here
    global_fault_view_c = rsf_pkg::READ_ZERO;
    global_fault_view_c[rsf_pkg::BIT_OTP_CRC]     =
      flags[rsf_pkg::FLAG_OTP_CRC];
    global_fault_view_c[rsf_pkg::BIT_BIQUAD]      =
      flags[rsf_pkg::FLAG_BIQUAD];
    global_fault_view_c[rsf_pkg::BIT_CLOCK_FAULT] =
      flags[rsf_pkg::FLAG_CLOCK];
  end
  assign global_fault_view = global_fault_view_c;

  // power stage protection
  assign channel_fault_flags_any = |flags[rsf_pkg::NUM_CHAN_FLAGS-1:0];
  // clock fault recovers on its own, so the live level drives Hi-Z
  assign hiz_next = channel_fault_flags_any | CLOCK_ERROR;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      hiz_reg     <= 1'b0;
      fault_n_reg <= 1'b1;
    end
    else
    begin
      hiz_reg     <= hiz_next;
      fault_n_reg <= ~(channel_fault_flags_any |
                       flags[rsf_pkg::FLAG_CLOCK]);
    end
  end

  assign OUTPUT_HIZ = hiz_reg;
  assign FAULT_N    = fault_n_reg;

  // read decode
  assign rd_spread_main  = addr_hit(REG_ADDR, rsf_pkg::OFF_SPREAD_MAIN);
  assign rd_spread_range = addr_hit(REG_ADDR, rsf_pkg::OFF_SPREAD_RANGE);
  assign rd_ramp_divisor = addr_hit(REG_ADDR, rsf_pkg::OFF_RAMP_DIVISOR);
  assign rd_step_sizes   = addr_hit(REG_ADDR, rsf_pkg::OFF_STEP_SIZES);
  assign rd_amp_boundary = addr_hit(REG_ADDR, rsf_pkg::OFF_AMP_BOUNDARY);
  assign rd_channel_fault_flags   = addr_hit(REG_ADDR, rsf_pkg::OFF_CHANNEL_FAULT_FLAGS);
  assign rd_global_fault = addr_hit(REG_ADDR, rsf_pkg::OFF_GLOBAL_FAULT);

  // unmapped and write-only addresses read as zero
  assign rdata_next =
    rd_spread_main  ? spread_main_reg   :
    rd_spread_range ? spread_range_reg  :
    rd_ramp_divisor ? ramp_divisor_reg  :
    rd_step_sizes   ? step_sizes_reg    :
    rd_amp_boundary ? amp_boundary_reg  :
    rd_channel_fault_flags   ? channel_fault_flags_view   :
    rd_global_fault ? global_fault_view :
                      rsf_pkg::READ_ZERO;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      rdata_reg  <= rsf_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= REG_RD;
      if (REG_RD)
        rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA  = rdata_reg;
  assign REG_RVALID = rvalid_reg;

  // controller settings
  assign manual_on = spread_main_reg[rsf_pkg::BIT_MANUAL];
  assign div2_next = manual_on &
                     spread_main_reg[rsf_pkg::BIT_PRE_DIV];

  assign random_range_field =
    spread_range_reg[rsf_pkg::RANDOM_RANGE_HI:rsf_pkg::RANDOM_RANGE_LO];
  assign tri_select_field =
    spread_range_reg[rsf_pkg::TRI_SEL_HI:rsf_pkg::TRI_SEL_LO];
  assign fall_step_field =
    step_sizes_reg[rsf_pkg::FALL_STEP_HI:rsf_pkg::FALL_STEP_LO];
  assign rise_step_field =
    step_sizes_reg[rsf_pkg::RISE_STEP_HI:rsf_pkg::RISE_STEP_LO];
  assign amp_field =
    amp_boundary_reg[rsf_pkg::AMP_HI:rsf_pkg::AMP_LO];
  assign boundary_field =
    amp_boundary_reg[rsf_pkg::BOUND_HI:rsf_pkg::BOUND_LO];

  // in auto mode the manual fields carry their reset defaults, whatever was written
  assign divisor_eff   = manual_on ? ramp_divisor_reg :
                         rsf_pkg::RST_RAMP_DIVISOR;
  assign fall_step_eff = manual_on ? fall_step_field :
    rsf_pkg::RST_STEP_SIZES[rsf_pkg::FALL_STEP_HI:
                            rsf_pkg::FALL_STEP_LO];
  assign rise_step_eff = manual_on ? rise_step_field :
    rsf_pkg::RST_STEP_SIZES[rsf_pkg::RISE_STEP_HI:
                            rsf_pkg::RISE_STEP_LO];
  assign amp_eff       = manual_on ? amp_field :
    rsf_pkg::RST_AMP_BOUNDARY[rsf_pkg::AMP_HI:
                              rsf_pkg::AMP_LO];
  assign boundary_eff  = manual_on ? boundary_field :
    rsf_pkg::RST_AMP_BOUNDARY[rsf_pkg::BOUND_HI:
                              rsf_pkg::BOUND_LO];

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      manual_reg       <= 1'b0;
      div2_reg         <= 1'b0;
      random_on_reg    <= 1'b0;
      tri_on_reg       <= 1'b0;
      random_range_reg <= 3'h0;
      tri_select_reg   <= 4'h0;
      divisor_out_reg  <= rsf_pkg::RST_RAMP_DIVISOR;
      fall_step_reg    <= rsf_pkg::RST_STEP_SIZES[rsf_pkg::FALL_STEP_HI:
                                                  rsf_pkg::FALL_STEP_LO];
      rise_step_reg    <= rsf_pkg::RST_STEP_SIZES[rsf_pkg::RISE_STEP_HI:
                                                  rsf_pkg::RISE_STEP_LO];
      amp_reg          <= rsf_pkg::RST_AMP_BOUNDARY[rsf_pkg::AMP_HI:
                                                    rsf_pkg::AMP_LO];
      boundary_reg     <= rsf_pkg::RST_AMP_BOUNDARY[rsf_pkg::BOUND_HI:
                                                    rsf_pkg::BOUND_LO];
    end
    else
    begin
      manual_reg       <= manual_on;
      div2_reg         <= div2_next;
      random_on_reg    <= spread_main_reg[rsf_pkg::BIT_RANDOM_ON];
      tri_on_reg       <= spread_main_reg[rsf_pkg::BIT_TRIANGLE_ON];
      random_range_reg <= random_range_field;
      tri_select_reg   <= tri_select_field;
      divisor_out_reg  <= divisor_eff;
      fall_step_reg    <= fall_step_eff;
      rise_step_reg    <= rise_step_eff;
      amp_reg          <= amp_eff;
      boundary_reg     <= boundary_eff;
    end
  end

  assign MANUAL_MODE             = manual_reg;
  assign SRC_DIV2                = div2_reg;
  assign RANDOM_SPREAD_ON        = random_on_reg;
  assign TRIANGLE_SPREAD_ON      = tri_on_reg;
  assign RANDOM_SPREAD_RANGE     = random_range_reg;
  assign TRIANGLE_SELECT         = tri_select_reg;
  assign MANUAL_RAMP_DIVISOR_N   = divisor_out_reg;
  assign TRIANGLE_FALL_STEP      = fall_step_reg;
  assign TRIANGLE_RISE_STEP      = rise_step_reg;
  assign RAMP_AMPLITUDE_SETTING  = amp_reg;
  assign TRIANGLE_SWEEP_BOUNDARY = boundary_reg;

endmodule // rsf_regs

// ===== verif/rsf_regs_asserts.sv
// rsf_regs_asserts: port-level checks of the ramp/fault register bank
`timescale 1ns/100ps
module rsf_regs_asserts
(
  // clock and reset
  input wire logic       CLOCK,
  input wire logic       RST_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // fault events
  input wire logic       LEFT_DC_EVT,
  input wire logic       RIGHT_DC_EVT,
  input wire logic       LEFT_OC_EVT,
  input wire logic       RIGHT_OC_EVT,
  input wire logic       OTP_CRC_EVT,
  input wire logic       CLOCK_ERROR,
  // settings and pins
  input wire logic       MANUAL_MODE,
  input wire logic       SRC_DIV2,
  input wire logic [7:0] MANUAL_RAMP_DIVISOR_N,
  input wire logic [3:0] TRIANGLE_FALL_STEP,
  input wire logic [3:0] TRIANGLE_RISE_STEP,
  input wire logic [1:0] RAMP_AMPLITUDE_SETTING,
  input wire logic [4:0] TRIANGLE_SWEEP_BOUNDARY,
  input wire logic       OUTPUT_HIZ,
  input wire logic       FAULT_N
);
  wire logic wr_main = REG_WR && (REG_ADDR == 8'h6b);
  wire logic clr = REG_WR && (REG_ADDR == 8'h78) && REG_WDATA[7];
  wire logic chan_evt = LEFT_DC_EVT || RIGHT_DC_EVT || LEFT_OC_EVT ||
                        RIGHT_OC_EVT;

  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  AST_MANUAL_ON: assert property (wr_main && REG_WDATA[4] |-> ##2 MANUAL_MODE)
    else $error("manual mode not taken from control write");
  AST_AUTO_OFF: assert property (wr_main && !REG_WDATA[4] |-> ##2
    (!MANUAL_MODE && !SRC_DIV2))
    else $error("auto mode write left manual or divide on");
  AST_DIV2: assert property (wr_main && REG_WDATA[5:4] == 2'b11
    |-> ##2 SRC_DIV2)
    else $error("pre-divide not applied in manual mode");
  AST_AUTO_DEFAULTS: assert property (!MANUAL_MODE |->
    {MANUAL_RAMP_DIVISOR_N, TRIANGLE_FALL_STEP, TRIANGLE_RISE_STEP,
     RAMP_AMPLITUDE_SETTING, TRIANGLE_SWEEP_BOUNDARY} == 23'h28_08a4)
    else $error("manual fields leak through in auto mode");
  AST_CHAN_PINS: assert property (chan_evt |-> ##2
    (OUTPUT_HIZ && !FAULT_N))
    else $error("channel fault did not reach hi-z and fault pin");
  AST_CLOCK_HIZ: assert property (CLOCK_ERROR |=> OUTPUT_HIZ)
    else $error("clock error did not force hi-z");
  AST_STICKY: assert property ($rose(FAULT_N) |-> $past(clr, 2))
    else $error("fault pin released without a clear write");
  AST_LEFT_DC_READ: assert property (LEFT_DC_EVT ##1
    (REG_RD && REG_ADDR == 8'h70) |=> REG_RDATA[3])
    else $error("left dc flag missing in read");
  AST_RIGHT_OC_READ: assert property (RIGHT_OC_EVT ##1
    (REG_RD && REG_ADDR == 8'h70) |=> REG_RDATA[0])
    else $error("right over-current flag missing in read");
  AST_OTP_READ: assert property (OTP_CRC_EVT ##1
    (REG_RD && REG_ADDR == 8'h71) |=> REG_RDATA[7])
    else $error("crc flag missing in read");
  AST_CLEAR_READS_ZERO: assert property (REG_RD && REG_ADDR == 8'h78
    |=> REG_RDATA == 8'h00)
    else $error("clear register read not zero");
endmodule // rsf_regs_asserts

// ===== verif/rsf_host_model.sv
// rsf_host_model: control-bus host issuing single-byte reads and writes
`timescale 1ns/100ps
module rsf_host_model
(
  // clock
  input  wire logic       CLOCK,
  // register port
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_WR,
  output logic            REG_RD,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_RVALID
);
  int timeouts = 0;

  initial
  begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end

  // idle lines are inverted so a stale value is never mistaken for a request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLOCK);
    REG_WR = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLOCK);
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    d = 8'hxx;
    for (n = 0; n < 4 && REG_RVALID !== 1'b1; n++)
      @(negedge CLOCK);
    if (REG_RVALID === 1'b1)
      d = REG_RDATA;
    else
      timeouts++;
  endtask
endmodule // rsf_host_model

// ===== verif/rsf_regs_tb_top.sv
// rsf_regs_tb_top: self-checking bench of the ramp/fault register bank
`timescale 1ns/100ps
module rsf_regs_tb_top;
  logic        clock;
  logic        rst_n;
  logic  [7:0] addr;
  logic  [7:0] wdata;
  logic        wr;
  logic        rd;
  logic  [7:0] rdata;
  logic        rvalid;
  logic  [6:0] evt;
  logic        clk_err;
  logic        manual;
  logic        div2;
  logic        rnd_on;
  logic        tri_on;
  logic  [2:0] rnd_rng;
  logic  [3:0] tri_sel;
  logic  [7:0] divn;
  logic  [3:0] fall;
  logic  [3:0] rise;
  logic  [1:0] amp;
  logic  [4:0] bnd;
  logic        hiz;
  logic        fault_n;
  logic  [7:0] v [5];
  int          i;
  int          n;
  int          bad_count = 0;
  int          checks = 0;
  wire logic [33:0] sets = {manual, div2, rnd_on, tri_on, rnd_rng, tri_sel,
                            divn, fall, rise, amp, bnd};
  localparam logic [7:0] AD [9] = '{8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f,
                                    8'h70, 8'h71, 8'h78, 8'h80};
  localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h50, 8'h11, 8'h24,
                                    8'h00, 8'h00, 8'h00, 8'h00};

  rsf_regs u_dut (
    .CLOCK(clock), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .LEFT_DC_EVT(evt[3]), .RIGHT_DC_EVT(evt[2]), .LEFT_OC_EVT(evt[1]),
    .RIGHT_OC_EVT(evt[0]), .OTP_CRC_EVT(evt[4]), .BIQUAD_WR_FAIL(evt[5]),
    .BIQUAD_WR_OK(evt[6]), .CLOCK_ERROR(clk_err), .MANUAL_MODE(manual),
    .SRC_DIV2(div2), .RANDOM_SPREAD_ON(rnd_on), .TRIANGLE_SPREAD_ON(tri_on),
    .RANDOM_SPREAD_RANGE(rnd_rng), .TRIANGLE_SELECT(tri_sel),
    .MANUAL_RAMP_DIVISOR_N(divn), .TRIANGLE_FALL_STEP(fall),
    .TRIANGLE_RISE_STEP(rise), .RAMP_AMPLITUDE_SETTING(amp),
    .TRIANGLE_SWEEP_BOUNDARY(bnd), .OUTPUT_HIZ(hiz), .FAULT_N(fault_n));

  rsf_host_model u_host (
    .CLOCK(clock), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid));

  // manual fields fall back to their reset values while in auto mode
  function automatic logic [33:0] exp_set(input logic [7:0] m, c, d, s, a);
    logic man;
    man = m[4];
    return {man, m[5] & man, m[1], m[0], c[6:4], c[3:0],
            man ? d : 8'h50, man ? s : 8'h11, man ? a[6:0] : 7'h24};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task give_verdict;
    bad_count += u_host.timeouts;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    if (u_host.timeouts != 0)
      give_verdict();
    chk(34'(d), 34'(exp));
  endtask

  task automatic pulse(input logic [6:0] e);
    @(negedge clock);
    evt = e;
    @(negedge clock);
    evt = 7'h00;
  endtask

  task automatic clear_all;
    u_host.wr(8'h78, 8'h80);
    repeat (2) @(negedge clock);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    rst_n = 1'b0;
    evt = 7'h00;
    clk_err = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    n = $urandom(81);
    for (i = 0; i < 9; i++)
      rdc(AD[i], RV[i]);
    chk(sets, exp_set(8'h00, 8'h00, 8'h50, 8'h11, 8'h24));
    $display("test reset_values done");
    for (n = 0; n < 24; n++)
    begin
      for (i = 0; i < 5; i++)
      begin
        v[i] = (n < 2) ? {8{n == 0}} : 8'($urandom);
        u_host.wr(8'h6b + 8'(i), v[i]);
      end
      u_host.wr(8'h70, 8'($urandom));
      u_host.wr(8'h71, 8'hff);
      chk(sets, exp_set(v[0], v[1], v[2], v[3], v[4]));
      for (i = 0; i < 5; i++)
        rdc(8'h6b + 8'(i), v[i]);
      rdc(8'h70, 8'h00);
      rdc(8'h71, 8'h00);
    end
    $display("test random_settings done");
    for (i = 0; i < 4; i++)
    begin
      // event stands into the read cycle so read-after-event checks fire
      @(negedge clock);
      evt = 7'(1 << i);
      rdc(8'h70, 8'(1 << i));
      evt = 7'h00;
      chk({hiz, fault_n}, 2'b10);
      u_host.wr(8'h78, 8'h7f);
      rdc(8'h70, 8'(1 << i));
      clear_all();
      rdc(8'h70, 8'h00);
      chk({hiz, fault_n}, 2'b01);
    end
    evt = 7'h0f;
    u_host.wr(8'h78, 8'h80);
    evt = 7'h00;
    rdc(8'h70, 8'h0f);
    clear_all();
    $display("test channel_faults done");
    @(negedge clock);
    evt = 7'h30;
    rdc(8'h71, 8'hc0);
    evt = 7'h00;
    pulse(7'h40);
    rdc(8'h71, 8'h80);
    clear_all();
    rdc(8'h71, 8'h00);
    clk_err = 1'b1;
    repeat (2) @(negedge clock);
    chk({hiz, fault_n}, 2'b10);
    rdc(8'h71, 8'h04);
    clk_err = 1'b0;
    repeat (2) @(negedge clock);
    chk({hiz, fault_n}, 2'b00);
    clear_all();
    chk({hiz, fault_n}, 2'b01);
    $display("test global_faults done");
    pulse(7'h7f);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rdc(8'h70, 8'h00);
    rdc(8'h71, 8'h00);
    chk({sets, hiz, fault_n}, {exp_set(8'h00, 8'h00, 8'h50, 8'h11, 8'h24),
        2'b01});
    $display("test midrun_reset done");
    give_verdict();
  end
endmodule // rsf_regs_tb_top

bind rsf_regs rsf_regs_asserts u_asserts (
  .CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .LEFT_DC_EVT(LEFT_DC_EVT), .RIGHT_DC_EVT(RIGHT_DC_EVT),
  .LEFT_OC_EVT(LEFT_OC_EVT), .RIGHT_OC_EVT(RIGHT_OC_EVT),
  .OTP_CRC_EVT(OTP_CRC_EVT), .CLOCK_ERROR(CLOCK_ERROR),
  .MANUAL_MODE(MANUAL_MODE), .SRC_DIV2(SRC_DIV2),
  .MANUAL_RAMP_DIVISOR_N(MANUAL_RAMP_DIVISOR_N),
  .TRIANGLE_FALL_STEP(TRIANGLE_FALL_STEP),
  .TRIANGLE_RISE_STEP(TRIANGLE_RISE_STEP),
  .RAMP_AMPLITUDE_SETTING(RAMP_AMPLITUDE_SETTING),
  .TRIANGLE_SWEEP_BOUNDARY(TRIANGLE_SWEEP_BOUNDARY),
  .OUTPUT_HIZ(OUTPUT_HIZ), .FAULT_N(FAULT_N));
